// file: pkg/fop_pkg.sv
// constants, carriers and enumerations for the flag offset / replay control block
// assumes one system clock; the two FIFO port clocks arrive as sampled levels

package fop_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned FOP_DATA_W       = 18;
    localparam int unsigned FOP_ADDR_W       = 15;   // shallower part
    localparam int unsigned FOP_OFS_W_SHALLOW = 15;  // 30-bit serial chain
    localparam int unsigned FOP_OFS_W_DEEP    = 16;  // 32-bit serial chain

    // ------------------------------------------------------------------
    // default offsets chosen by the strap at full reset
    // ------------------------------------------------------------------
    localparam logic [15:0] FOP_DEF_SERIAL   = 16'h03ff;
    localparam logic [15:0] FOP_DEF_PARALLEL = 16'h007f;

    // ------------------------------------------------------------------
    // timing: port-clock edges from offset load to a valid partial flag
    // ------------------------------------------------------------------
    localparam logic [1:0] FOP_FLAG_LAT = 2'h2;
    localparam logic [1:0] FOP_CNT_LAST = 2'h1;
    localparam logic [1:0] FOP_CNT_IDLE = 2'h0;

    // offset register pointer positions
    localparam logic FOP_PTR_EMPTY = 1'b0;
    localparam logic FOP_PTR_FULL  = 1'b1;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic load_select;
        logic write_strobe_n;
        logic read_strobe_n;
        logic serial_enable_n;
        logic replay_request_n;
    } fop_ctrl_t;

    typedef struct packed {
        logic empty_or_valid_n;  // empty_indicator_n or output_valid_n
        logic full_or_room_n;    // full_indicator_n, or input_room_n (high = full)
        logic half_level_n;
        logic almost_empty_n;
        logic almost_full_n;
    } fop_flags_t;

    typedef struct packed {
        logic mem_wr;
        logic mem_rd;
        logic ofs_wr;
        logic ofs_rd;
        logic ser;
    } fop_op_t;

    typedef enum logic { FOP_METH_PARALLEL, FOP_METH_SERIAL } fop_meth_t;
    typedef enum { FOP_RT_IDLE, FOP_RT_SETUP } fop_rt_state_t;

endpackage

// file: verification/fop_port_model.sv
// port clock model: writer and reader controllers making one port edge per two-cycle request
// assumes requests are levels set by the bench after a sys clock edge
`timescale 1ns/100ps

module fop_port_model (
    // clock
    input  wire logic i_sys_clk,
    // requests
    input  wire logic i_w_req,
    input  wire logic i_r_req,
    // port clocks, idle low between requests
    output logic      o_wclk,
    output logic      o_rclk
);
    // a held request gives a rise every second sys clock; offset read never beside a write
    always_ff @(posedge i_sys_clk) begin
        o_wclk <= i_w_req & ~o_wclk;
        o_rclk <= i_r_req & ~i_w_req & ~o_rclk;
    end
endmodule

// file: verification/test_fop_ctrl.sv
// bench for fop_ctrl: offset load, readback, pointer wrap and replay
// assumes a 20 MHz system clock and port clocks from fop_port_model
`timescale 1ns/100ps

module test_fop_ctrl import fop_pkg::*;;
    logic i_sys_clk = 0, i_nrst = 0, i_partial_reset_n = 1, w_req = 0, r_req = 0, sbit = 0;
    logic wclk, rclk, o_serial_method, o_fall_through_mode;
    logic [4:0] ctrl = 5'h1f;
    logic [17:0] din = 0, o_data_output_bus;
    logic [29:0] chain = {15'h3fff, 15'h0155};
    fop_flags_t o_flags;
    int err_count = 0, checks = 0, cyc = 0;
    always #25 i_sys_clk = ~i_sys_clk;
    fop_port_model pm (.i_sys_clk(i_sys_clk), .i_w_req(w_req), .i_r_req(r_req), .o_wclk(wclk), .o_rclk(rclk));
    // smallest depth that still holds a full-width offset
    fop_ctrl #(.ADDR_W(14)) uut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_partial_reset_n(i_partial_reset_n),
        .i_write_side_clock(wclk), .i_read_side_clock(rclk), .i_ctrl(fop_ctrl_t'(ctrl)),
        .i_mode_or_bit_input(sbit), .i_data_input_bus(din), .o_data_output_bus(o_data_output_bus),
        .o_flags(o_flags), .o_serial_method(o_serial_method), .o_fall_through_mode(o_fall_through_mode));
    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // controls held across the whole port edge, released afterwards
    task automatic edge_op(input logic w, input logic [4:0] c, input logic [17:0] d, input logic b);
        ctrl <= c;
        din <= d;
        sbit <= b;
        w_req <= w;
        r_req <= ~w;
        repeat (2) @(posedge i_sys_clk);
        w_req <= 1'b0;
        r_req <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        ctrl <= 5'h1f;
        repeat (2) @(posedge i_sys_clk);
    endtask
    // straps stable through reset and the capture edge
    task automatic do_reset(input logic ls, input logic ft);
        ctrl <= {ls, 4'hf};
        sbit <= ft;
        i_nrst <= 1'b0;
        repeat (16) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        ctrl <= 5'h1f;
    endtask
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge i_sys_clk) begin
        if (++cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end
    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        @(posedge i_sys_clk);
        do_reset(1'b0, 1'b0);
        chk(18'(o_serial_method), 18'h0);
        chk(18'(o_flags), 18'h0d);
        edge_op(1'b0, 5'h0b, 18'h0, 1'b0);
        chk(o_data_output_bus, 18'h7f);
        edge_op(1'b0, 5'h0b, 18'h0, 1'b0);
        chk(o_data_output_bus, 18'h7f);
        edge_op(1'b1, 5'h07, 18'h30011, 1'b0);
        edge_op(1'b0, 5'h0b, 18'h0, 1'b0);
        chk(o_data_output_bus, 18'h11); // upper data bits dropped
        edge_op(1'b1, 5'h07, 18'h00022, 1'b0);
        edge_op(1'b1, 5'h07, 18'h00033, 1'b0); // wraps to empty offset
        // read pointer sits on the full offset across the partial reset
        @(posedge i_sys_clk) i_partial_reset_n <= 1'b0;
        @(posedge i_sys_clk) i_partial_reset_n <= 1'b1;
        edge_op(1'b1, 5'h17, 18'h00abc, 1'b0); // memory write pauses readback
        edge_op(1'b0, 5'h0b, 18'h0, 1'b0);
        chk(o_data_output_bus, 18'h22);
        edge_op(1'b0, 5'h0b, 18'h0, 1'b0);
        chk(o_data_output_bus, 18'h33);
        $display("parallel offsets done");
        edge_op(1'b0, 5'h1e, 18'h0, 1'b0);
        chk(18'(o_flags.empty_or_valid_n), 18'h0);
        edge_op(1'b0, 5'h1f, 18'h0, 1'b0);
        chk(18'(o_flags.empty_or_valid_n), 18'h1);
        $display("replay done");
        do_reset(1'b1, 1'b0);
        chk(18'(o_serial_method), 18'h1);
        edge_op(1'b0, 5'h0b, 18'h0, 1'b0);
        chk(o_data_output_bus, 18'h3ff);
        edge_op(1'b1, 5'h07, 18'h00055, 1'b0); // refused in serial method
        edge_op(1'b0, 5'h0b, 18'h0, 1'b0);
        chk(o_data_output_bus, 18'h3ff);
        for (int i = 0; i < 30; i++) begin
            edge_op(1'b1, 5'h0d, 18'h0, chain[i]);
            // memory write in the pause must not move the bit position
            if (i == 10) edge_op(1'b1, 5'h17, 18'h00abc, ~chain[i+1]);
        end
        chk(18'(o_flags.almost_full_n), 18'h1); // still invalid
        edge_op(1'b0, 5'h0b, 18'h0, 1'b0);
        chk(o_data_output_bus, 18'h0155);
        edge_op(1'b0, 5'h0b, 18'h0, 1'b0);
        chk(o_data_output_bus, 18'h3fff);
        edge_op(1'b1, 5'h1f, 18'h0, 1'b0);
        chk(18'(o_flags.almost_full_n), 18'h1); // one write edge is not enough
        edge_op(1'b1, 5'h1f, 18'h0, 1'b0);
        chk(18'(o_flags.almost_full_n), 18'h0); // one stored word meets the threshold
        $display("serial offsets done");
        do_reset(1'b0, 1'b1);
        chk(18'(o_fall_through_mode), 18'h1);
        edge_op(1'b1, 5'h17, 18'h00abc, 1'b0); // one word before replay
        edge_op(1'b0, 5'h1f, 18'h0, 1'b0);
        chk(o_data_output_bus, 18'h00abc); // first word falls through
        edge_op(1'b0, 5'h1e, 18'h0, 1'b0);
        chk(18'(o_flags.empty_or_valid_n), 18'h1);
        edge_op(1'b0, 5'h1f, 18'h0, 1'b0);
        chk(18'(o_flags.empty_or_valid_n), 18'h0);
        chk(o_data_output_bus, 18'h00abc);
        $display("fall-through replay done");
        stop_test();
    end
endmodule

// file: verilog/fop_ctrl.sv
// flag offset programming, offset readback and replay control of a dual-port FIFO
// assumes port clocks and controls are synchronous levels sampled on i_sys_clk
//
// Contract
// - parallel offset write on write-clock edge
// - parallel offset readback on read-clock edge
// - serial shift one bit per write edge
// - load_select high means plain memory access
// - programming method fixed at full reset only
// - parallel readback always; no serial readback
// - serial reload needs complete bit set
// - serial shift pauses and resumes in sequence
// - flags valid two edges after last bit
// - write pointer: empty, full, wrap
// - read pointer: empty, full, wrap independently
// - readback overwrites the output word
// - full reset homes offset pointers; partial keeps
// - parallel programming pauses, resumes next register
// - readback pauses, resumes at same pointer
// - each flag valid two edges after load
// - replay sampled low on read edge starts setup
// - standard mode: empty low during setup
// - fall-through: valid_n high, then first word
// - flag update timing after replay setup
// - strap picks method and default offsets
// - mode strap pin becomes serial bit input
// - partial reset keeps offsets and method
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps

module fop_ctrl import fop_pkg::*; #(
    parameter int unsigned DATA_W = FOP_DATA_W,
    parameter int unsigned ADDR_W = FOP_ADDR_W,
    parameter int unsigned OFS_W  = FOP_OFS_W_SHALLOW
) (
    // clock and resets
    input  wire logic              i_sys_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_partial_reset_n,
    // fifo port clocks, sampled
    input  wire logic              i_write_side_clock,
    input  wire logic              i_read_side_clock,
    // control pins
    input  wire fop_ctrl_t         i_ctrl,
    input  wire logic              i_mode_or_bit_input,
    input  wire logic [DATA_W-1:0] i_data_input_bus,
    // data and status
    output logic [DATA_W-1:0]      o_data_output_bus,
    output fop_flags_t             o_flags,
    output logic                   o_serial_method,
    output logic                   o_fall_through_mode
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    localparam int unsigned CHAIN_W = 2 * OFS_W;
    generate
        if ((OFS_W != FOP_OFS_W_SHALLOW && OFS_W != FOP_OFS_W_DEEP) || OFS_W > ADDR_W + 1 ||
            DATA_W < OFS_W || ADDR_W < 2) begin : g_bad_cfg
            $error("fop_ctrl: unsupported width parameters");
        end
    endgenerate

    localparam logic [ADDR_W:0] DEPTH_C = {1'b1, {ADDR_W{1'b0}}};
    localparam logic [ADDR_W:0] HALF_C  = {2'b01, {(ADDR_W-1){1'b0}}};
    localparam logic [5:0]      LAST_BIT = 6'(CHAIN_W - 1);

    // ------------------------------------------------------------------
    // pin decode
    // ------------------------------------------------------------------
    function automatic fop_op_t decode_op(input fop_ctrl_t c);
        fop_op_t o;
        o = '0;
        if (c.load_select) begin
            o.mem_wr = !c.write_strobe_n;
            o.mem_rd = !c.read_strobe_n;
        end else begin
            o.ofs_wr = !c.write_strobe_n && c.read_strobe_n && c.serial_enable_n;
            o.ofs_rd = c.write_strobe_n && !c.read_strobe_n && c.serial_enable_n;
            o.ser    = c.write_strobe_n && c.read_strobe_n && !c.serial_enable_n;
        end
        return o;
    endfunction

    fop_op_t         op;
    logic            wclk_q_reg, rclk_q_reg;
    logic            w_edge, r_edge;
    logic            strap_done_reg, run;
    fop_meth_t       method_reg;
    logic            ft_mode_reg;
    logic [CHAIN_W-1:0] ofs_chain_reg;
    logic [OFS_W-1:0]   ofs_empty, ofs_full;
    logic [5:0]      ser_cnt_reg;
    logic            wr_ofs_ptr_reg, rd_ofs_ptr_reg;
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [ADDR_W:0] wr_ptr_reg, rd_ptr_reg, count;
    logic [DATA_W-1:0] q_reg;
    logic            q_valid_reg;
    fop_rt_state_t   rt_state_reg;
    logic            rt_start;
    logic            ser_act, par_wr_act, ofs_rd_act, ser_last;
    logic            pae_done, paf_done;
    logic [1:0]      pae_cnt_reg, paf_cnt_reg;
    logic            pae_valid_reg, paf_valid_reg;
    logic [1:0]      pae_pipe_reg, paf_pipe_reg;

    assign op        = decode_op(i_ctrl);
    assign w_edge    = i_write_side_clock && !wclk_q_reg;
    assign r_edge    = i_read_side_clock && !rclk_q_reg;
    assign run       = strap_done_reg && i_partial_reset_n;
    assign ofs_empty = ofs_chain_reg[OFS_W-1:0];
    assign ofs_full  = ofs_chain_reg[CHAIN_W-1:OFS_W];
    assign count     = wr_ptr_reg - rd_ptr_reg;

    // ------------------------------------------------------------------
    // port clock edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wclk_q_reg <= 1'b0;
            rclk_q_reg <= 1'b0;
        end else begin
            wclk_q_reg <= i_write_side_clock;
            rclk_q_reg <= i_read_side_clock;
        end
    end

    // ------------------------------------------------------------------
    // straps, caught once on the first clock after full reset release
    // ------------------------------------------------------------------
    // partial reset cannot reach this, so method and mode survive it
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            strap_done_reg <= 1'b0;
            method_reg     <= FOP_METH_PARALLEL;
            ft_mode_reg    <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            method_reg     <= i_ctrl.load_select ? FOP_METH_SERIAL : FOP_METH_PARALLEL;
            ft_mode_reg    <= i_mode_or_bit_input;
        end
    end

    // ------------------------------------------------------------------
    // offset storage: one chain, empty offset in the low half
    // ------------------------------------------------------------------
    assign ser_act    = run && w_edge && op.ser && method_reg == FOP_METH_SERIAL;
    assign par_wr_act = run && w_edge && op.ofs_wr && method_reg == FOP_METH_PARALLEL;
    assign ofs_rd_act = run && r_edge && op.ofs_rd;
    assign ser_last   = ser_act && ser_cnt_reg == LAST_BIT;

    // serial bits enter at the top and walk down, so the first bit ends as empty lsb
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ofs_chain_reg <= '0;
        end else if (!strap_done_reg) begin
            ofs_chain_reg <= i_ctrl.load_select ?
                {FOP_DEF_SERIAL[OFS_W-1:0], FOP_DEF_SERIAL[OFS_W-1:0]} :
                {FOP_DEF_PARALLEL[OFS_W-1:0], FOP_DEF_PARALLEL[OFS_W-1:0]};
        end else if (ser_act) begin
            ofs_chain_reg <= {i_mode_or_bit_input, ofs_chain_reg[CHAIN_W-1:1]};
        end else if (par_wr_act) begin
            if (wr_ofs_ptr_reg == FOP_PTR_EMPTY)
                ofs_chain_reg[OFS_W-1:0] <= i_data_input_bus[OFS_W-1:0];
            else
                ofs_chain_reg[CHAIN_W-1:OFS_W] <= i_data_input_bus[OFS_W-1:0];
        end
    end

    // serial bit position, kept across pauses
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ser_cnt_reg <= '0;
        end else if (ser_act) begin
            ser_cnt_reg <= ser_last ? 6'h00 : ser_cnt_reg + 6'h01;
        end
    end

    // offset pointers; partial reset does not touch them
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ofs_ptr_reg <= FOP_PTR_EMPTY;
            rd_ofs_ptr_reg <= FOP_PTR_EMPTY;
        end else begin
            if (par_wr_act)
                wr_ofs_ptr_reg <= !wr_ofs_ptr_reg;
            if (ofs_rd_act)
                rd_ofs_ptr_reg <= !rd_ofs_ptr_reg;
        end
    end

    // ------------------------------------------------------------------
    // fifo memory write side
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (run && w_edge && op.mem_wr && count != DEPTH_C)
            mem[wr_ptr_reg[ADDR_W-1:0]] <= i_data_input_bus;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr_reg <= '0;
        end else if (!i_partial_reset_n) begin
            wr_ptr_reg <= '0;
        end else if (run && w_edge && op.mem_wr && count != DEPTH_C) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // read side: memory reads, offset readback and replay setup
    // ------------------------------------------------------------------
    // the host keeps both strobes high while requesting replay
    assign rt_start = run && r_edge && rt_state_reg == FOP_RT_IDLE &&
                      !i_ctrl.replay_request_n && i_ctrl.read_strobe_n && i_ctrl.write_strobe_n;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rt_state_reg <= FOP_RT_IDLE;
        end else if (!i_partial_reset_n) begin
            rt_state_reg <= FOP_RT_IDLE;
        end else if (run && r_edge) begin
            case (rt_state_reg)
                FOP_RT_IDLE:  rt_state_reg <= rt_start ? FOP_RT_SETUP : FOP_RT_IDLE;
                FOP_RT_SETUP: rt_state_reg <= FOP_RT_IDLE;
                default:      rt_state_reg <= FOP_RT_IDLE;
            endcase
        end
    end

    // output word, read pointer and fall-through valid in one process
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_ptr_reg  <= '0;
            q_reg       <= '0;
            q_valid_reg <= 1'b0;
        end else if (!i_partial_reset_n) begin
            rd_ptr_reg  <= '0;
            q_reg       <= '0;
            q_valid_reg <= 1'b0;
        end else if (run && r_edge) begin
            if (rt_start) begin
                rd_ptr_reg  <= '0;
                q_valid_reg <= 1'b0;
            end else if (rt_state_reg == FOP_RT_SETUP) begin
                if (ft_mode_reg && wr_ptr_reg != '0) begin
                    q_reg       <= mem[0];
                    rd_ptr_reg  <= {{ADDR_W{1'b0}}, 1'b1};
                    q_valid_reg <= 1'b1;
                end
            end else if (ofs_rd_act) begin
                q_reg <= rd_ofs_ptr_reg == FOP_PTR_EMPTY ?
                         DATA_W'(ofs_empty) : DATA_W'(ofs_full);
            end else if (ft_mode_reg) begin
                // fall-through keeps one word parked on the outputs
                if ((!q_valid_reg || op.mem_rd) && count != '0) begin
                    q_reg       <= mem[rd_ptr_reg[ADDR_W-1:0]];
                    rd_ptr_reg  <= rd_ptr_reg + 1'b1;
                    q_valid_reg <= 1'b1;
                end else if (op.mem_rd) begin
                    q_valid_reg <= 1'b0;
                end
            end else if (op.mem_rd && count != '0) begin
                q_reg      <= mem[rd_ptr_reg[ADDR_W-1:0]];
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // partial flag validity after programming
    // ------------------------------------------------------------------
    // a new serial pass or a parallel write voids the flag until loaded
    assign paf_done = ser_last || (par_wr_act && wr_ofs_ptr_reg == FOP_PTR_FULL);
    assign pae_done = ser_last || (par_wr_act && wr_ofs_ptr_reg == FOP_PTR_EMPTY);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            paf_cnt_reg   <= FOP_CNT_IDLE;
            paf_valid_reg <= 1'b1;
        end else if (paf_done) begin
            paf_cnt_reg   <= FOP_FLAG_LAT;
            paf_valid_reg <= 1'b0;
        end else if ((ser_act && ser_cnt_reg == 6'h00) || (par_wr_act && !paf_done)) begin
            paf_valid_reg <= 1'b0;
        end else if (w_edge && paf_cnt_reg != FOP_CNT_IDLE) begin
            paf_cnt_reg   <= paf_cnt_reg - 2'h1;
            paf_valid_reg <= paf_cnt_reg == FOP_CNT_LAST;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pae_cnt_reg   <= FOP_CNT_IDLE;
            pae_valid_reg <= 1'b1;
        end else if (pae_done) begin
            pae_cnt_reg   <= FOP_FLAG_LAT;
            pae_valid_reg <= 1'b0;
        end else if ((ser_act && ser_cnt_reg == 6'h00) || (par_wr_act && !pae_done)) begin
            pae_valid_reg <= 1'b0;
        end else if (r_edge && pae_cnt_reg != FOP_CNT_IDLE) begin
            pae_cnt_reg   <= pae_cnt_reg - 2'h1;
            pae_valid_reg <= pae_cnt_reg == FOP_CNT_LAST;
        end
    end

    // ------------------------------------------------------------------
    // flag pipelines: two port-clock edges from the level change
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            paf_pipe_reg <= '0;
            pae_pipe_reg <= 2'h3;
        end else if (!i_partial_reset_n) begin
            paf_pipe_reg <= '0;
            pae_pipe_reg <= 2'h3;
        end else begin
            if (w_edge)
                paf_pipe_reg <= {paf_pipe_reg[0],
                                 count >= DEPTH_C - (ADDR_W+1)'(ofs_full)};
            if (r_edge)
                pae_pipe_reg <= {pae_pipe_reg[0], count <= (ADDR_W+1)'(ofs_empty)};
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // half level follows the pointers directly, so a replay moves it at once
    always_comb begin
        // standard empty indicator is low while empty and through the whole replay setup
        o_flags.empty_or_valid_n = ft_mode_reg ? !q_valid_reg :
            (rt_state_reg == FOP_RT_IDLE && count != '0);
        o_flags.full_or_room_n   = ft_mode_reg ? (count == DEPTH_C) : (count != DEPTH_C);
        o_flags.half_level_n     = !(count > HALF_C);
        o_flags.almost_empty_n   = pae_valid_reg ? !pae_pipe_reg[1] : 1'b0;
        o_flags.almost_full_n    = paf_valid_reg ? !paf_pipe_reg[1] : 1'b1;
    end

    assign o_data_output_bus   = q_reg;
    assign o_serial_method     = method_reg == FOP_METH_SERIAL;
    assign o_fall_through_mode = ft_mode_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_rt_start;
        rt_start;
    endsequence

    sequence s_rt_finish;
        run && r_edge && rt_state_reg == FOP_RT_SETUP;
    endsequence

    a_ofs_write_seq: assert property (par_wr_act && wr_ofs_ptr_reg == FOP_PTR_EMPTY |=>
        ofs_empty == $past(i_data_input_bus[OFS_W-1:0]) && wr_ofs_ptr_reg == FOP_PTR_FULL)
        else $error("offset write did not hit empty register");
    a_ofs_read_seq: assert property (ofs_rd_act && !rt_start && rt_state_reg == FOP_RT_IDLE &&
        rd_ofs_ptr_reg == FOP_PTR_FULL |=> q_reg == DATA_W'(ofs_full) && rd_ofs_ptr_reg == FOP_PTR_EMPTY)
        else $error("offset readback wrong register");
    a_serial_shift: assert property (ser_act |=> ofs_chain_reg[CHAIN_W-1] == $past(i_mode_or_bit_input))
        else $error("serial bit not shifted in");
    a_serial_pause: assert property (strap_done_reg && !ser_act |=> $stable(ser_cnt_reg))
        else $error("serial position moved while paused");
    a_method_hold: assert property (strap_done_reg |=> $stable(method_reg) && $stable(ft_mode_reg))
        else $error("programming method changed after reset");
    a_nop_state: assert property (run && w_edge && i_ctrl.write_strobe_n && i_ctrl.read_strobe_n &&
        i_ctrl.serial_enable_n |=> $stable(ofs_chain_reg) && $stable(wr_ptr_reg))
        else $error("no-operation changed state");
    a_paf_latency: assert property (paf_done ##1 (!paf_done && !ser_act && !par_wr_act)[*2] |->
        !paf_valid_reg)
        else $error("full threshold flag valid too early");
    a_paf_valid: assert property (w_edge && paf_cnt_reg == FOP_CNT_LAST && !paf_done && !ser_act &&
        !par_wr_act |=> paf_valid_reg)
        else $error("full threshold flag not valid after two edges");
    a_rt_setup: assert property (s_rt_start |=> rd_ptr_reg == '0 && o_flags.empty_or_valid_n == ft_mode_reg)
        else $error("replay setup did not rewind or flag");
    a_rt_finish: assert property (s_rt_finish ##0 (ft_mode_reg && wr_ptr_reg != '0) |=>
        !o_flags.empty_or_valid_n && q_reg == mem[0])
        else $error("fall-through replay did not present first word");
    a_partial_keep: assert property (strap_done_reg && !i_partial_reset_n |=>
        $stable(ofs_chain_reg) && $stable(wr_ofs_ptr_reg) && $stable(rd_ofs_ptr_reg))
        else $error("partial reset disturbed offsets");

endmodule
